// [verilog/timing_param_set.sv]
// Display timing parameter set with monitor range compliance check
`timescale 1ns/100ps
`include "timing_param_cfg.svh"

module timing_param_set #(
    parameter logic [15:0] HW_HMIN = 16'h000f,
    parameter logic [15:0] HW_HMAX = 16'h00c8,
    parameter logic [15:0] HW_VMIN = 16'h0018,
    parameter logic [15:0] HW_VMAX = 16'h00f0,
    parameter logic [15:0] HW_PMAX = 16'h0190
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync polarity and verdict
    output logic hsync_positive,
    output logic vsync_positive,
    output logic timing_accept
);

    // Software registers
    logic [5:0] ctrl_reg, ctrl_next;
    timing_param_pkg::freq_t requested_frequency_value, req_next;
    timing_param_pkg::freq_t hpix_reg, hpix_next;
    timing_param_pkg::freq_t vlines_reg, vlines_next;
    timing_param_pkg::small_t char_cell_width, cell_next;
    timing_param_pkg::freq_t margin_reg, margin_next;
    timing_param_pkg::small_t porch_reg, porch_next;
    timing_param_pkg::small_t vsw_reg, vsw_next;
    timing_param_pkg::small_t hsp_reg, hsp_next;
    timing_param_pkg::freq_t vsbp_reg, vsbp_next;
    timing_param_pkg::freq_t grad_reg, grad_next;
    timing_param_pkg::small_t offs_reg, offs_next;
    logic [8:0] scale_reg, scale_next;
    timing_param_pkg::small_t weight_reg, weight_next;
    logic [1:0] mon_reg, mon_next;
    timing_param_pkg::freq_t mhmin_reg, mhmin_next, mhmax_reg, mhmax_next;
    timing_param_pkg::freq_t mvmin_reg, mvmin_next, mvmax_reg, mvmax_next;
    timing_param_pkg::freq_t mpmax_reg, mpmax_next;
    timing_param_pkg::freq_t line_rate_khz, cand_h_next;
    timing_param_pkg::freq_t requested_refresh_rate, cand_v_next;
    timing_param_pkg::freq_t cand_p_reg, cand_p_next;
    // Bus answer
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next;
    // Derived state
    logic [5:0] status_reg, status_next;
    logic [31:0] vert_reg, vert_next;
    logic [31:0] blank_reg, blank_next;
    logic [31:0] horz_reg, horz_next;
    logic hpol_next, vpol_next, accept_next;

    // Effective parameters
    logic custom;
    logic margin_request_flag, interlace_request_flag;
    logic [1:0] sel;
    timing_param_pkg::freq_t e_margin, e_vsbp, e_grad;
    timing_param_pkg::small_t e_porch, vert_sync_width_lines, e_hsp, e_offs;
    timing_param_pkg::small_t e_weight;
    logic [8:0] e_scale;
    timing_param_pkg::freq_t vert_sync_backporch_min_time;

    assign custom = ctrl_reg[`CTRL_BIDIR];
    assign margin_request_flag = ctrl_reg[`CTRL_MARGIN];
    assign interlace_request_flag = ctrl_reg[`CTRL_INTERLACE];
    assign sel = ctrl_reg[`CTRL_SEL_HI:`CTRL_SEL_LO];
    assign e_margin = custom ? margin_reg : `DEF_MARGIN_PM;
    assign e_porch = custom ? porch_reg : `DEF_PORCH;
    assign vert_sync_width_lines = custom ? vsw_reg : `DEF_VSYNC_W;
    assign e_hsp = custom ? hsp_reg : `DEF_HSYNC_PCT;
    assign e_vsbp = custom ? vsbp_reg : `DEF_VSBP_US;
    assign e_grad = custom ? grad_reg : `DEF_GRAD_M;
    assign e_offs = custom ? offs_reg : `DEF_OFFS_C;
    assign e_scale = custom ? scale_reg : `DEF_SCALE_K;
    assign e_weight = custom ? weight_reg : `DEF_WEIGHT_J;
    assign vert_sync_backporch_min_time = e_vsbp;

    // Register write and read
    logic access, wr_en, mapped;
    assign access = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        req_next = requested_frequency_value;
        hpix_next = hpix_reg;
        vlines_next = vlines_reg;
        cell_next = char_cell_width;
        margin_next = margin_reg;
        porch_next = porch_reg;
        vsw_next = vsw_reg;
        hsp_next = hsp_reg;
        vsbp_next = vsbp_reg;
        grad_next = grad_reg;
        offs_next = offs_reg;
        scale_next = scale_reg;
        weight_next = weight_reg;
        mon_next = mon_reg;
        mhmin_next = mhmin_reg;
        mhmax_next = mhmax_reg;
        mvmin_next = mvmin_reg;
        mvmax_next = mvmax_reg;
        mpmax_next = mpmax_reg;
        cand_h_next = line_rate_khz;
        cand_v_next = requested_refresh_rate;
        cand_p_next = cand_p_reg;
        mapped = 1'b1;
        prdata_next = 32'h00000000;
        unique case (paddr)
            `OFS_CTRL: prdata_next = {26'h0, ctrl_reg};
            `OFS_REQ_FREQ: prdata_next = {16'h0, requested_frequency_value};
            `OFS_H_PIXELS: prdata_next = {16'h0, hpix_reg};
            `OFS_V_LINES: prdata_next = {16'h0, vlines_reg};
            `OFS_CELL: prdata_next = {24'h0, char_cell_width};
            `OFS_MARGIN_PM: prdata_next = {16'h0, margin_reg};
            `OFS_PORCH: prdata_next = {24'h0, porch_reg};
            `OFS_VSYNC_W: prdata_next = {24'h0, vsw_reg};
            `OFS_HSYNC_PCT: prdata_next = {24'h0, hsp_reg};
            `OFS_VSBP_US: prdata_next = {16'h0, vsbp_reg};
            `OFS_GRAD_M: prdata_next = {16'h0, grad_reg};
            `OFS_OFFS_C: prdata_next = {24'h0, offs_reg};
            `OFS_SCALE_K: prdata_next = {23'h0, scale_reg};
            `OFS_WEIGHT_J: prdata_next = {24'h0, weight_reg};
            `OFS_MON_CFG: prdata_next = {30'h0, mon_reg};
            `OFS_MON_HMIN: prdata_next = {16'h0, mhmin_reg};
            `OFS_MON_HMAX: prdata_next = {16'h0, mhmax_reg};
            `OFS_MON_VMIN: prdata_next = {16'h0, mvmin_reg};
            `OFS_MON_VMAX: prdata_next = {16'h0, mvmax_reg};
            `OFS_MON_PMAX: prdata_next = {16'h0, mpmax_reg};
            `OFS_CAND_H: prdata_next = {16'h0, line_rate_khz};
            `OFS_CAND_V: prdata_next = {16'h0, requested_refresh_rate};
            `OFS_CAND_P: prdata_next = {16'h0, cand_p_reg};
            `OFS_STATUS: prdata_next = {26'h0, status_reg};
            `OFS_VERT: prdata_next = vert_reg;
            `OFS_BLANK: prdata_next = blank_reg;
            `OFS_HORZ: prdata_next = horz_reg;
            default: mapped = 1'b0;
        endcase
        if (wr_en)
        begin
            unique case (paddr)
                `OFS_CTRL: ctrl_next = pwdata[5:0];
                `OFS_REQ_FREQ: req_next = pwdata[15:0];
                `OFS_H_PIXELS: hpix_next = pwdata[15:0];
                `OFS_V_LINES: vlines_next = pwdata[15:0];
                `OFS_CELL: cell_next = pwdata[7:0];
                `OFS_MARGIN_PM: margin_next = pwdata[15:0];
                `OFS_PORCH: porch_next = pwdata[7:0];
                `OFS_VSYNC_W: vsw_next = pwdata[7:0];
                `OFS_HSYNC_PCT: hsp_next = pwdata[7:0];
                `OFS_VSBP_US: vsbp_next = pwdata[15:0];
                `OFS_GRAD_M: grad_next = pwdata[15:0];
                `OFS_OFFS_C: offs_next = pwdata[7:0];
                `OFS_SCALE_K: scale_next = pwdata[8:0];
                `OFS_WEIGHT_J: weight_next = pwdata[7:0];
                `OFS_MON_CFG: mon_next = pwdata[1:0];
                `OFS_MON_HMIN: mhmin_next = pwdata[15:0];
                `OFS_MON_HMAX: mhmax_next = pwdata[15:0];
                `OFS_MON_VMIN: mvmin_next = pwdata[15:0];
                `OFS_MON_VMAX: mvmax_next = pwdata[15:0];
                `OFS_MON_PMAX: mpmax_next = pwdata[15:0];
                `OFS_CAND_H: cand_h_next = pwdata[15:0];
                `OFS_CAND_V: cand_v_next = pwdata[15:0];
                `OFS_CAND_P: cand_p_next = pwdata[15:0];
                default: mapped = mapped;
            endcase
        end
        pready_next = access;
        pslverr_next = access & ~mapped;
        if (!access)
            prdata_next = 32'h00000000;
    end

    // Derived timing figures
    logic [31:0] vmarg_prod, hmarg_prod, vsbp_prod;
    logic [15:0] field_lines, vmarg, hmarg_pix, hmarg_cells;
    logic [15:0] vsbp_lines, bp_lines;
    logic signed [17:0] c_diff;
    logic signed [26:0] c_scaled;
    logic signed [17:0] c_eff, duty;
    logic [24:0] m_scaled;
    logic [16:0] m_eff;
    logic [16:0] m_over_f;
    logic sel_ok, compliant, in_mon, in_hw;
    timing_param_pkg::freq_t def_freq;

    always_comb
    begin
        // Per-field line count
        field_lines = interlace_request_flag ? {1'b0, vlines_reg[15:1]}
                                             : vlines_reg;
        vmarg_prod = vlines_reg * e_margin + `PERMILLE_HALF;
        hmarg_prod = hpix_reg * e_margin + `PERMILLE_HALF;
        vmarg = margin_request_flag ? 16'(vmarg_prod / `PERMILLE)
                                    : 16'h0000;
        hmarg_pix = margin_request_flag ? 16'(hmarg_prod / `PERMILLE)
                                        : 16'h0000;
        // Whole cells only; a zero width falls back to the default
        hmarg_cells = (char_cell_width == 8'h00)
            ? 16'(hmarg_pix / `DEF_CELL)
            : 16'(hmarg_pix / char_cell_width);
        vsbp_prod = vert_sync_backporch_min_time * line_rate_khz
                    + `US_PER_MS_M1;
        vsbp_lines = 16'(vsbp_prod / `PERMILLE);
        bp_lines = (vsbp_lines > 16'(vert_sync_width_lines))
            ? vsbp_lines - 16'(vert_sync_width_lines)
            : 16'h0000;
        c_diff = $signed({10'h0, e_offs}) - $signed({10'h0, e_weight});
        c_scaled = c_diff * $signed({1'b0, e_scale});
        c_eff = 18'(c_scaled >>> `SCALE_DIV_SHIFT)
                + $signed({10'h0, e_weight});
        m_scaled = e_grad * e_scale;
        m_eff = 17'(m_scaled >> `SCALE_DIV_SHIFT);
        m_over_f = (line_rate_khz == 16'h0000) ? 17'h00000
                   : 17'(m_eff / line_rate_khz);
        duty = c_eff - $signed({1'b0, m_over_f});
        if (duty < 0)
            duty = 18'sh00000;
        sel_ok = (sel == `SEL_REFRESH) | (sel == `SEL_LINE_RATE)
                 | (sel == `SEL_PIXCLK);
        unique case (sel)
            `SEL_REFRESH: def_freq = requested_refresh_rate;
            `SEL_LINE_RATE: def_freq = line_rate_khz;
            `SEL_PIXCLK: def_freq = cand_p_reg;
            default: def_freq = 16'h0000;
        endcase
        compliant = mon_reg[`MON_GTF_FLAG]
                    & mon_reg[`MON_RANGE_DESC];
        in_mon = (line_rate_khz >= mhmin_reg) & (line_rate_khz <= mhmax_reg)
            & (requested_refresh_rate >= mvmin_reg)
            & (requested_refresh_rate <= mvmax_reg)
            & (cand_p_reg <= mpmax_reg);
        in_hw = (line_rate_khz >= HW_HMIN) & (line_rate_khz <= HW_HMAX)
            & (requested_refresh_rate >= HW_VMIN)
            & (requested_refresh_rate <= HW_VMAX)
            & (cand_p_reg <= HW_PMAX);
        accept_next = sel_ok & compliant & in_mon & in_hw
            & (def_freq == requested_frequency_value);
        hpol_next = ctrl_reg[`CTRL_SECOND];
        vpol_next = ~ctrl_reg[`CTRL_SECOND];
        status_next = {custom, vpol_next, hpol_next, sel_ok, compliant,
                       accept_next};
        vert_next = {vmarg, field_lines};
        blank_next = {8'(duty), vert_sync_width_lines, 8'(bp_lines),
                      e_porch};
        horz_next = {hmarg_cells, 8'(hpix_reg + hmarg_cells
                     * char_cell_width * 2 > 16'h0000), e_hsp};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `DEF_CTRL;
            requested_frequency_value <= 16'h0000;
            hpix_reg <= 16'h0000;
            vlines_reg <= 16'h0000;
            char_cell_width <= `DEF_CELL;
            margin_reg <= `DEF_MARGIN_PM;
            porch_reg <= `DEF_PORCH;
            vsw_reg <= `DEF_VSYNC_W;
            hsp_reg <= `DEF_HSYNC_PCT;
            vsbp_reg <= `DEF_VSBP_US;
            grad_reg <= `DEF_GRAD_M;
            offs_reg <= `DEF_OFFS_C;
            scale_reg <= `DEF_SCALE_K;
            weight_reg <= `DEF_WEIGHT_J;
            mon_reg <= 2'h0;
            mhmin_reg <= 16'h0000;
            mhmax_reg <= 16'h0000;
            mvmin_reg <= 16'h0000;
            mvmax_reg <= 16'h0000;
            mpmax_reg <= 16'h0000;
            line_rate_khz <= 16'h0000;
            requested_refresh_rate <= 16'h0000;
            cand_p_reg <= 16'h0000;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            status_reg <= 6'h00;
            vert_reg <= 32'h00000000;
            blank_reg <= 32'h00000000;
            horz_reg <= 32'h00000000;
            hsync_positive <= 1'b0;
            vsync_positive <= 1'b1;
            timing_accept <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_reg <= ctrl_next;
            requested_frequency_value <= req_next;
            hpix_reg <= hpix_next;
            vlines_reg <= vlines_next;
            char_cell_width <= cell_next;
            margin_reg <= margin_next;
            porch_reg <= porch_next;
            vsw_reg <= vsw_next;
            hsp_reg <= hsp_next;
            vsbp_reg <= vsbp_next;
            grad_reg <= grad_next;
            offs_reg <= offs_next;
            scale_reg <= scale_next;
            weight_reg <= weight_next;
            mon_reg <= mon_next;
            mhmin_reg <= mhmin_next;
            mhmax_reg <= mhmax_next;
            mvmin_reg <= mvmin_next;
            mvmax_reg <= mvmax_next;
            mpmax_reg <= mpmax_next;
            line_rate_khz <= cand_h_next;
            requested_refresh_rate <= cand_v_next;
            cand_p_reg <= cand_p_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            status_reg <= status_next;
            vert_reg <= vert_next;
            blank_reg <= blank_next;
            horz_reg <= horz_next;
            hsync_positive <= hpol_next;
            vsync_positive <= vpol_next;
            timing_accept <= accept_next;
        end
    end

endmodule : timing_param_set

// [verilog/timing_param_cfg.svh]
// Register offsets, field positions and reset values of the timing parameter set
`ifndef TIMING_PARAM_CFG_SVH
`define TIMING_PARAM_CFG_SVH

`define OFS_CTRL        8'h00
`define OFS_REQ_FREQ    8'h04
`define OFS_H_PIXELS    8'h08
`define OFS_V_LINES     8'h0c
`define OFS_CELL        8'h10
`define OFS_MARGIN_PM   8'h14
`define OFS_PORCH       8'h18
`define OFS_VSYNC_W     8'h1c
`define OFS_HSYNC_PCT   8'h20
`define OFS_VSBP_US     8'h24
`define OFS_GRAD_M      8'h28
`define OFS_OFFS_C      8'h2c
`define OFS_SCALE_K     8'h30
`define OFS_WEIGHT_J    8'h34
`define OFS_MON_CFG     8'h38
`define OFS_MON_HMIN    8'h3c
`define OFS_MON_HMAX    8'h40
`define OFS_MON_VMIN    8'h44
`define OFS_MON_VMAX    8'h48
`define OFS_MON_PMAX    8'h4c
`define OFS_CAND_H      8'h50
`define OFS_CAND_V      8'h54
`define OFS_CAND_P      8'h58
`define OFS_STATUS      8'h5c
`define OFS_VERT        8'h60
`define OFS_BLANK       8'h64
`define OFS_HORZ        8'h68

`define CTRL_MARGIN     0
`define CTRL_INTERLACE  1
`define CTRL_BIDIR      2
`define CTRL_SECOND     3
`define CTRL_SEL_LO     4
`define CTRL_SEL_HI     5
`define MON_GTF_FLAG    0
`define MON_RANGE_DESC  1

`define SEL_REFRESH     2'h1
`define SEL_LINE_RATE   2'h2
`define SEL_PIXCLK      2'h3

`define DEF_MARGIN_PM   16'h0012
`define DEF_CELL        8'h08
`define DEF_PORCH       8'h01
`define DEF_VSYNC_W     8'h03
`define DEF_HSYNC_PCT   8'h08
`define DEF_VSBP_US     16'h0226
`define DEF_GRAD_M      16'h0258
`define DEF_OFFS_C      8'h28
`define DEF_SCALE_K     9'h080
`define DEF_WEIGHT_J    8'h14
`define DEF_CTRL        6'h10

`define SCALE_DIV_SHIFT 8
`define PERMILLE        32'h000003e8
`define PERMILLE_HALF   32'h000001f4
`define US_PER_MS_M1    32'h000003e7

`endif

// [verilog/timing_param_pkg.sv]
// Types shared by the timing parameter set
package timing_param_pkg;
    typedef logic [15:0] freq_t;
    typedef logic [7:0] small_t;
endpackage : timing_param_pkg

// [test/monitor_ident_model.sv]
// Model of the attached monitor's identification data
`timescale 1ns/100ps
module monitor_ident_model #(
    parameter logic [31:0] H_MIN = 32'h0000001e,
    parameter logic [31:0] H_MAX = 32'h00000064,
    parameter logic [31:0] V_MIN = 32'h00000032,
    parameter logic [31:0] V_MAX = 32'h00000078,
    parameter logic [31:0] P_MAX = 32'h000000c8
) (
    // Feature flags and advertised ranges
    output logic [31:0] feature_bits,
    output logic [31:0] line_min,
    output logic [31:0] line_max,
    output logic [31:0] frame_min,
    output logic [31:0] frame_max,
    output logic [31:0] pixclk_max
);
    // Formula flag set and range descriptor present
    assign feature_bits = 32'h00000003;
    // Advertised ranges in kHz, Hz and MHz
    assign line_min = H_MIN;
    assign line_max = H_MAX;
    assign frame_min = V_MIN;
    assign frame_max = V_MAX;
    assign pixclk_max = P_MAX;
endmodule : monitor_ident_model

// [test/timing_param_props.sv]
// Checker of bus timing and polarity outputs of the timing parameter set
`timescale 1ns/100ps
module timing_param_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hsync_positive,
    input wire logic vsync_positive,
    input wire logic timing_accept
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable && ce;
    endsequence
    sequence access_s;
        psel && penable && ce && !pready;
    endsequence
    AST_ONE_WAIT: assert property (setup_s ##1 access_s |=> pready)
        else $error("pready missing one cycle into access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_NO_READY_IDLE: assert property (!(psel && penable) |=> !pready)
        else $error("pready without an access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && prdata == 0)
        else $error("pslverr outside its answer cycle");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
        else $error("prdata not zero outside answer");
    AST_UNMAPPED: assert property (
        (access_s ##0 paddr > 8'h68) |=> pready && pslverr)
        else $error("unmapped address not refused");
    AST_POL_EXCL: assert property (hsync_positive != vsync_positive)
        else $error("both sync polarities equal");
    AST_POL_CAUSE: assert property ($changed(hsync_positive) |->
        $past(psel && penable && pready && pwrite && paddr == 8'h00, 2))
        else $error("polarity changed without control write");
    AST_ACCEPT_RESET: assert property ($rose(presetn) |->
        !timing_accept ##1 !timing_accept)
        else $error("timing accepted straight after reset");
endmodule : timing_param_props

bind timing_param_set timing_param_props chk (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_positive(hsync_positive), .vsync_positive(vsync_positive),
    .timing_accept(timing_accept));

// [test/timing_param_set_tb.sv]
// Self-checking bench of the timing parameter set
`timescale 1ns/100ps
`include "timing_param_cfg.svh"
module timing_param_set_tb;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic hsync_positive, vsync_positive, timing_accept;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, fb, hmn, hmx, vmn, vmx, pmx;
    int errors, n_compared, cycles;
    logic [7:0] def_ofs [11] = '{`OFS_CTRL, `OFS_CELL, `OFS_MARGIN_PM,
        `OFS_PORCH, `OFS_VSYNC_W, `OFS_HSYNC_PCT, `OFS_VSBP_US, `OFS_GRAD_M,
        `OFS_OFFS_C, `OFS_SCALE_K, `OFS_WEIGHT_J};
    logic [31:0] def_val [11] = '{32'h10, 32'h8, 32'h12, 32'h1, 32'h3,
        32'h8, 32'h226, 32'h258, 32'h28, 32'h80, 32'h14};
    logic [7:0] bad_ofs [5] = '{`OFS_MON_CFG, `OFS_CAND_H, `OFS_CAND_V,
        `OFS_CTRL, `OFS_REQ_FREQ};
    logic [31:0] bad_val [5] = '{32'h1, 32'h82, 32'h6e, 32'h0, 32'h3d};
    logic [31:0] good_val [5] = '{32'h3, 32'h1e, 32'h3c, 32'h10, 32'h3c};
    logic [31:0] req_val [3] = '{32'h3c, 32'h1e, 32'h19};

    timing_param_set #(.HW_VMAX(16'h0064)) uut (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hsync_positive(hsync_positive),
        .vsync_positive(vsync_positive), .timing_accept(timing_accept));
    monitor_ident_model mon (.feature_bits(fb), .line_min(hmn),
        .line_max(hmx), .frame_min(vmn), .frame_max(vmx), .pixclk_max(pmx));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task end_of_test;
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            end_of_test();
        end
    end

    task chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk

    // One APB transfer; answer taken at the edge that samples pready high
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp,
        input logic [31:0] mask);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rd & mask);
    endtask : rchk

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rchk("default", def_ofs[i], def_val[i], '1);
        for (int i = 5; i < 8; i++)
            rchk("default", def_ofs[i], def_val[i], '1);
        for (int i = 8; i < 11; i++)
            rchk("default", def_ofs[i], def_val[i], '1);
        chk("vsync_pos", 32'h1, 32'(vsync_positive));
        rchk("unmapped", 8'h70, 32'h0, '1);
        chk("unmapped_err", 32'h1, 32'(err));
        wr(`OFS_MON_CFG, fb);
        wr(`OFS_MON_HMIN, hmn);
        wr(`OFS_MON_HMAX, hmx);
        wr(`OFS_MON_VMIN, vmn);
        wr(`OFS_MON_VMAX, vmx);
        wr(`OFS_MON_PMAX, pmx);
        wr(`OFS_CAND_H, 32'h1e);
        wr(`OFS_CAND_V, 32'h3c);
        wr(`OFS_CAND_P, 32'h19);
        wr(`OFS_V_LINES, 32'h1e0);
        wr(`OFS_H_PIXELS, 32'h280);
        for (int i = 1; i < 4; i++)
        begin
            wr(`OFS_REQ_FREQ, req_val[i-1]);
            wr(`OFS_CTRL, 32'(i) << 4);
            rchk("accept_sel", `OFS_STATUS, 32'h1, 32'h1);
            chk("accept_pin", 32'h1, 32'(timing_accept));
        end
        wr(`OFS_REQ_FREQ, 32'h3c);
        wr(`OFS_CTRL, 32'h10);
        for (int i = 0; i < 5; i++)
        begin
            wr(bad_ofs[i], bad_val[i]);
            rchk("deny", `OFS_STATUS, 32'h0, 32'h1);
            chk("refused_pin", 32'h0, 32'(timing_accept));
            wr(bad_ofs[i], good_val[i]);
            rchk("restored", `OFS_STATUS, 32'h1, 32'h1);
        end
        rchk("blank", `OFS_BLANK, 32'h14030e01, '1);
        rchk("porch", `OFS_BLANK, 32'h00030001, 32'h00ff00ff);
        wr(`OFS_CTRL, 32'h11);
        rchk("vert_margin", `OFS_VERT, 32'h000901e0, '1);
        rchk("horz", `OFS_HORZ, 32'h00010008, 32'hffff00ff);
        wr(`OFS_CTRL, 32'h12);
        rchk("vert_field", `OFS_VERT, 32'h000000f0, '1);
        wr(`OFS_CELL, 32'h4);
        wr(`OFS_CTRL, 32'h11);
        rchk("cell", `OFS_HORZ, 32'h00030000, 32'hffff0000);
        wr(`OFS_VSYNC_W, 32'h5);
        rchk("vsync_def", `OFS_BLANK, 32'h00030000, 32'h00ff0000);
        wr(`OFS_CTRL, 32'h15);
        rchk("vsync_own", `OFS_BLANK, 32'h00050c00, 32'h00ffff00);
        wr(`OFS_CTRL, 32'h18);
        rchk("pol_status", `OFS_STATUS, 32'h08, 32'h18);
        chk("hsync_pos", 32'h1, 32'(hsync_positive));
        chk("vsync_neg", 32'h0, 32'(vsync_positive));
        chk("accept_end", 32'h1, 32'(timing_accept));
        // Reset in mid-run while a timing stands accepted
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("rst_mon", `OFS_MON_CFG, 32'h0, '1);
        chk("rst_accept", 32'h0, 32'(timing_accept));
        chk("rst_hsync", 32'h0, 32'(hsync_positive));
        chk("rst_vsync", 32'h1, 32'(vsync_positive));
        rchk("rst_ctrl", `OFS_CTRL, 32'h10, '1);
        end_of_test();
    end
endmodule : timing_param_set_tb
